//--- hw/pmt_timer.sv
// Period match timer with AXI4-Lite registers and a masked interrupt.
//
// Our own choices: the register addresses and the AXI4-Lite register port.
`include "pmt_cfg.svh"
`default_nettype none
module pmt_timer (
	input wire logic core_clk,
	input wire logic resetn,
	// AXI4-Lite write address channel.
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// AXI4-Lite write data channel.
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response channel.
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read address channel.
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// AXI4-Lite read data channel.
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Level interrupt request.
	output logic irq
);

	////////////////////////////////////////////////////////////////////////////////
	// Declarations.

	logic awready_q; // Write address slot free.
	logic wready_q; // Write data slot free.
	logic aw_held_q; // A write address has been taken.
	logic w_held_q; // Write data have been taken.
	logic [7:0] awaddr_q; // Held write address.
	logic [31:0] wdata_q; // Held write data.
	logic [3:0] wstrb_q; // Held write strobes.
	logic bvalid_q; // Write response pending.
	logic [1:0] bresp_q; // Write response code.
	logic arready_q; // Read address slot free.
	logic rvalid_q; // Read data pending.
	logic [31:0] rdata_q; // Read data word.
	logic [1:0] rresp_q; // Read response code.
	logic irq_q; // Registered interrupt request.

	pmt_pkg::pmt_byte_t ctrl_q; // Control register, bit 7 stays zero.
	pmt_pkg::pmt_byte_t period_q; // Period match value.
	pmt_pkg::pmt_byte_t count_q; // Running count.
	logic flag_q; // Sticky match interrupt flag.
	logic enable_q; // Match interrupt enable.
	logic [1:0] instr_q; // Core clock to instruction clock divider.

	logic wr_go; // One-cycle pulse that performs a write.
	pmt_pkg::pmt_reg_e wr_sel; // Register addressed by the write.
	logic wr_lane0; // Byte lane 0 is enabled.
	logic wr_ctrl; // Control register written this cycle.
	logic wr_period; // Period register written this cycle.
	logic wr_count; // Count register written this cycle.
	logic wr_status; // Status register written this cycle.
	logic wr_mask; // Mask register written this cycle.
	logic instr_tick; // One pulse per instruction clock.
	logic run_tick; // Instruction tick while the timer runs.
	logic pre_tick; // Raw prescaler output, before the write gate.
	logic inc; // Prescaled count increment.
	logic match; // Increment that finds count equal to period.
	logic post_evt; // Postscaler output event.
	logic scaler_clr; // Clears prescaler and postscaler.
	pmt_pkg::pmt_reg_e rd_sel; // Register addressed by the read.
	pmt_pkg::pmt_byte_t rd_byte; // Byte returned by the read.

	////////////////////////////////////////////////////////////////////////////////
	// Bus outputs come straight from flip-flops.

	assign s_axi_awready = awready_q;
	assign s_axi_wready = wready_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_arready = arready_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;
	assign irq = irq_q;

	////////////////////////////////////////////////////////////////////////////////
	// Write path.

	// Address and data are taken in either order; each slot closes until the response.
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			awready_q <= 1'b1;
			aw_held_q <= 1'b0;
			awaddr_q <= 8'h00;
		end else if (s_axi_awvalid && awready_q) begin
			awready_q <= 1'b0;
			aw_held_q <= 1'b1;
			awaddr_q <= s_axi_awaddr;
		end else if (bvalid_q && s_axi_bready) begin
			// Reopen only once the response is gone, so one write is under way.
			awready_q <= 1'b1;
			aw_held_q <= 1'b0;
		end
	end

	// Write data slot works like the address slot.
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			wready_q <= 1'b1;
			w_held_q <= 1'b0;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
		end else if (s_axi_wvalid && wready_q) begin
			wready_q <= 1'b0;
			w_held_q <= 1'b1;
			wdata_q <= s_axi_wdata;
			wstrb_q <= s_axi_wstrb;
		end else if (bvalid_q && s_axi_bready) begin
			wready_q <= 1'b1;
			w_held_q <= 1'b0;
		end
	end

	// The write acts in the one cycle where both halves are held and no response waits.
	assign wr_go = aw_held_q && w_held_q && !bvalid_q;
	assign wr_sel = pmt_pkg::pmt_decode(awaddr_q);
	// All registers are one byte wide, so only lane 0 carries a write.
	assign wr_lane0 = wr_go && wstrb_q[0];
	assign wr_ctrl = wr_lane0 && (wr_sel == pmt_pkg::PMT_SEL_CTRL);
	assign wr_period = wr_lane0 && (wr_sel == pmt_pkg::PMT_SEL_PERIOD);
	assign wr_count = wr_lane0 && (wr_sel == pmt_pkg::PMT_SEL_COUNT);
	assign wr_status = wr_lane0 && (wr_sel == pmt_pkg::PMT_SEL_STATUS);
	assign wr_mask = wr_lane0 && (wr_sel == pmt_pkg::PMT_SEL_MASK);

	// Response follows the write by one cycle; an unmapped address answers SLVERR.
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			bvalid_q <= 1'b0;
			bresp_q <= `PMT_RESP_OKAY;
		end else if (wr_go) begin
			bvalid_q <= 1'b1;
			bresp_q <= (wr_sel == pmt_pkg::PMT_SEL_NONE) ? `PMT_RESP_SLVERR : `PMT_RESP_OKAY;
		end else if (s_axi_bready) begin
			bvalid_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read path.

	// Read mux; unused high bits and reserved bits read as zero.
	always_comb begin
		rd_sel = pmt_pkg::pmt_decode(s_axi_araddr);
		case (rd_sel)
			pmt_pkg::PMT_SEL_CTRL: rd_byte = ctrl_q & `PMT_CTRL_MASK;
			pmt_pkg::PMT_SEL_PERIOD: rd_byte = period_q;
			pmt_pkg::PMT_SEL_COUNT: rd_byte = count_q;
			pmt_pkg::PMT_SEL_STATUS: rd_byte = {7'h00, flag_q};
			pmt_pkg::PMT_SEL_MASK: rd_byte = {7'h00, enable_q};
			default: rd_byte = 8'h00;
		endcase
	end

	// The address is taken, the data follow one cycle later and stand until rready.
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			arready_q <= 1'b1;
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			rresp_q <= `PMT_RESP_OKAY;
		end else if (s_axi_arvalid && arready_q) begin
			arready_q <= 1'b0;
			rvalid_q <= 1'b1;
			rdata_q <= {24'h00_0000, rd_byte};
			rresp_q <= (rd_sel == pmt_pkg::PMT_SEL_NONE) ? `PMT_RESP_SLVERR : `PMT_RESP_OKAY;
		end else if (rvalid_q && s_axi_rready) begin
			rvalid_q <= 1'b0;
			arready_q <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Registers written by software.

	// Control register; bit 7 is never stored.
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			ctrl_q <= `PMT_CTRL_RST;
		end else if (wr_ctrl) begin
			ctrl_q <= wdata_q[7:0] & `PMT_CTRL_MASK;
		end
	end

	// Period register, reset to all ones so a fresh timer runs the full range.
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			period_q <= `PMT_PERIOD_RST;
		end else if (wr_period) begin
			period_q <= wdata_q[7:0];
		end
	end

	// Interrupt enable bit.
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			enable_q <= 1'b0;
		end else if (wr_mask) begin
			enable_q <= wdata_q[`PMT_FLAG_BIT];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Counting chain.

	// Free-running divider that makes the instruction clock tick.
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			instr_q <= 2'h0;
		end else begin
			instr_q <= instr_q + 2'h1;
		end
	end

	assign instr_tick = (instr_q == `PMT_INSTR_LAST);
	// A stopped timer feeds no ticks to the prescaler, so it freezes too.
	assign run_tick = instr_tick && ctrl_q[`PMT_RUN_BIT];
	// Writes to count or control restart the hidden scalers.
	assign scaler_clr = wr_count || wr_ctrl;

	pmt_prescale u_prescale (
		.core_clk(core_clk),
		.resetn(resetn),
		.tick_in(run_tick),
		.clear(scaler_clr),
		.select(ctrl_q[`PMT_PRE_MSB:`PMT_PRE_LSB]),
		.tick_out(pre_tick)
	);

	// A scaler-clearing write drops the tick that it meets, so a control write keeps the count.
	assign inc = pre_tick && !scaler_clr;

	// The comparison runs continuously; it acts on the increment that finds equality.
	assign match = inc && (count_q == period_q);

	// Count register; a software write wins over an increment in the same cycle.
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			count_q <= `PMT_COUNT_RST;
		end else if (wr_count) begin
			count_q <= wdata_q[7:0];
		end else if (match) begin
			count_q <= `PMT_COUNT_RST;
		end else if (inc) begin
			count_q <= count_q + 8'h01;
		end
	end

	pmt_postscale u_postscale (
		.core_clk(core_clk),
		.resetn(resetn),
		.match_in(match && !scaler_clr),
		.clear(scaler_clr),
		.select(ctrl_q[`PMT_POST_MSB:`PMT_POST_LSB]),
		.event_out(post_evt)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Interrupt.

	// Sticky flag, cleared by writing one; a new event in the same cycle wins.
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			flag_q <= 1'b0;
		end else if (post_evt) begin
			flag_q <= 1'b1;
		end else if (wr_status && wdata_q[`PMT_FLAG_BIT]) begin
			flag_q <= 1'b0;
		end
	end

	// Request rises one cycle after the flag and its enable are both set, and falls one cycle after either clears.
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= flag_q && enable_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks.

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!resetn);

	sequence s_tick_gap;
		!instr_tick [*3] ##1 instr_tick;
	endsequence

	a_instr_rate: assert property (instr_tick |=> s_tick_gap)
		else $error("instruction tick not every fourth clock");
	a_count_reload: assert property (match && !wr_count |=> count_q == 8'h00)
		else $error("count did not reload after a match");
	a_count_step: assert property (inc && !match && !wr_count |=>
		count_q == $past(count_q) + 8'h01)
		else $error("count did not step");
	a_stop_holds: assert property (!ctrl_q[`PMT_RUN_BIT] && !wr_count && !wr_ctrl |=>
		$stable(count_q))
		else $error("stopped timer changed its count");
	a_ctrl_keeps: assert property (wr_ctrl && !wr_count |=> $stable(count_q))
		else $error("control write disturbed the count");
	a_period_load: assert property (wr_period |=> period_q == $past(wdata_q[7:0]))
		else $error("period write lost");
	a_flag_set: assert property (post_evt |=> flag_q)
		else $error("postscaler event did not set the flag");
	a_irq_follow: assert property (##1 irq_q == $past(flag_q && enable_q))
		else $error("interrupt does not follow flag and enable");
	a_ctrl_bit7: assert property (s_axi_arvalid && arready_q &&
		rd_sel == pmt_pkg::PMT_SEL_CTRL |=> rvalid_q && rdata_q[31:7] == 25'h0)
		else $error("control read shows bit 7");
endmodule
`default_nettype wire

//--- hw/pmt_cfg.svh
// Register offsets, field positions, reset values and timing counts of the period match timer.
`ifndef PMT_CFG_SVH
`define PMT_CFG_SVH

// Byte offsets of the registers on the register bus.
`define PMT_OFF_CTRL 8'h00
`define PMT_OFF_PERIOD 8'h04
`define PMT_OFF_COUNT 8'h08
`define PMT_OFF_STATUS 8'h0c
`define PMT_OFF_MASK 8'h10

// Control register field positions.
`define PMT_POST_MSB 6
`define PMT_POST_LSB 3
`define PMT_RUN_BIT 2
`define PMT_PRE_MSB 1
`define PMT_PRE_LSB 0
`define PMT_CTRL_MASK 8'h7f

// Reset values.
`define PMT_CTRL_RST 8'h00
`define PMT_PERIOD_RST 8'hff
`define PMT_COUNT_RST 8'h00

// Status and mask bit of the match interrupt.
`define PMT_FLAG_BIT 0

// Instruction clock is the core clock divided by four.
`define PMT_INSTR_LAST 2'h3

// Prescaler terminal counts for divide by 1, 4 and 16.
`define PMT_PRE_LAST1 4'h0
`define PMT_PRE_LAST4 4'h3
`define PMT_PRE_LAST16 4'hf

// AXI responses.
`define PMT_RESP_OKAY 2'h0
`define PMT_RESP_SLVERR 2'h2

`endif

//--- hw/pmt_pkg.sv
// Types and the shared address decode of the period match timer.
`include "pmt_cfg.svh"
`default_nettype none
package pmt_pkg;
	// One byte of timer state.
	typedef logic [7:0] pmt_byte_t;
	// Register selected by a bus address.
	typedef enum logic [2:0] {
		PMT_SEL_CTRL,
		PMT_SEL_PERIOD,
		PMT_SEL_COUNT,
		PMT_SEL_STATUS,
		PMT_SEL_MASK,
		PMT_SEL_NONE
	} pmt_reg_e;

	// Decodes a byte address into a register select; used by read and write paths.
	function automatic pmt_reg_e pmt_decode(input logic [7:0] addr);
		pmt_reg_e sel;
		sel = PMT_SEL_NONE;
		case (addr)
			`PMT_OFF_CTRL: sel = PMT_SEL_CTRL;
			`PMT_OFF_PERIOD: sel = PMT_SEL_PERIOD;
			`PMT_OFF_COUNT: sel = PMT_SEL_COUNT;
			`PMT_OFF_STATUS: sel = PMT_SEL_STATUS;
			`PMT_OFF_MASK: sel = PMT_SEL_MASK;
			default: sel = PMT_SEL_NONE;
		endcase
		return sel;
	endfunction
endpackage
`default_nettype wire

//--- hw/pmt_prescale.sv
// Prescaler that divides the instruction tick by 1, 4 or 16.
`include "pmt_cfg.svh"
`default_nettype none
module pmt_prescale (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic tick_in,
	input wire logic clear,
	input wire logic [1:0] select,
	output logic tick_out
);
	// Hidden divider state; software can neither read nor write it.
	logic [3:0] cnt_q;
	// Terminal count chosen by the select code.
	logic [3:0] last;

	// Code 00 divides by 1, 01 by 4, and 1x by 16.
	always_comb begin
		case (select)
			2'h0: last = `PMT_PRE_LAST1;
			2'h1: last = `PMT_PRE_LAST4;
			default: last = `PMT_PRE_LAST16;
		endcase
	end

	// The output pulses on the tick that closes a full division.
	assign tick_out = tick_in && (cnt_q >= last);

	// Counter wraps at the terminal count; a clear restarts the division.
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			cnt_q <= 4'h0;
		end else if (clear) begin
			cnt_q <= 4'h0;
		end else if (tick_in) begin
			cnt_q <= (cnt_q >= last) ? 4'h0 : cnt_q + 4'h1;
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!resetn);

	a_pre_bypass: assert property (select == 2'h0 |-> tick_out == tick_in)
		else $error("divide by one does not pass every tick");
	a_pre_clear: assert property (clear |=> cnt_q == 4'h0)
		else $error("prescaler not cleared");
endmodule
`default_nettype wire

//--- hw/pmt_postscale.sv
// Postscaler that turns every n-th period match into one output event.
`default_nettype none
module pmt_postscale (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic match_in,
	input wire logic clear,
	input wire logic [3:0] select,
	output logic event_out
);
	// Hidden match counter.
	logic [3:0] cnt_q;

	// The event fires on the match that makes select plus one matches.
	assign event_out = match_in && (cnt_q >= select);

	// Each match advances the counter; the event restarts it.
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			cnt_q <= 4'h0;
		end else if (clear) begin
			cnt_q <= 4'h0;
		end else if (match_in) begin
			cnt_q <= (cnt_q >= select) ? 4'h0 : cnt_q + 4'h1;
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!resetn);

	a_post_advance: assert property (match_in && !clear && !event_out |=>
		cnt_q == $past(cnt_q) + 4'h1)
		else $error("postscaler did not advance on a match");
	a_post_clear: assert property (clear |=> cnt_q == 4'h0)
		else $error("postscaler not cleared");
endmodule
`default_nettype wire

//--- sim/tb_period_match_timer_8bit.sv
// Self-checking testbench of the period match timer, driven over its register bus.
`include "pmt_cfg.svh"
`default_nettype none
module tb_period_match_timer_8bit;
	timeunit 1ns;
	timeprecision 1ps;

	////////////////////////////////////////////////////////////////////////////////
	logic core_clk = 1'b0; // 200 MHz core clock.
	logic resetn = 1'b0; // Held low for the first cycles.
	logic [7:0] s_axi_awaddr = 8'h00;
	logic s_axi_awvalid = 1'b0;
	logic s_axi_awready;
	logic [31:0] s_axi_wdata = 32'h00000000;
	logic [3:0] s_axi_wstrb = 4'hf; // Every write covers the significant byte.
	logic s_axi_wvalid = 1'b0;
	logic s_axi_wready;
	logic [1:0] s_axi_bresp;
	logic s_axi_bvalid;
	logic s_axi_bready = 1'b1; // Always willing, so no ready toggles twice in a step.
	logic [7:0] s_axi_araddr = 8'h00;
	logic s_axi_arvalid = 1'b0;
	logic s_axi_arready;
	logic [31:0] s_axi_rdata;
	logic [1:0] s_axi_rresp;
	logic s_axi_rvalid;
	logic s_axi_rready = 1'b1;
	logic irq;
	int bad_count = 0; // Mismatches seen.
	int n_compared = 0; // Comparisons made.
	int ps_tab[4] = '{0, 1, 7, 15}; // Postscale codes at both ends and between.

	pmt_timer i_dut (
		.core_clk(core_clk), .resetn(resetn),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .irq(irq)
	);

	// Half period of 2.5 ns gives the 200 MHz clock.
	always #2.5 core_clk = ~core_clk;

	////////////////////////////////////////////////////////////////////////////////
	// Prints the counts and the verdict, then stops the run.
	task automatic end_sim();
		$display("Compared %0d values, %0d mismatches", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// Compares a seen value with the expected one and counts both outcomes.
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// A bus wait that never ends counts as a mismatch and closes the run.
	task automatic give_up(input int n);
		if (n > 40) begin
			check(32'h0, 32'h1);
			end_sim();
		end
	endtask

	// One write; address and data are offered together and each released once taken.
	task automatic bus_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
		int n;
		logic aw_done;
		logic w_done;
		n = 0;
		aw_done = 1'b0;
		w_done = 1'b0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		forever begin
			@(posedge core_clk);
			n++;
			give_up(n);
			if (s_axi_bvalid && aw_done && w_done) begin
				resp = s_axi_bresp;
				break;
			end
			if (!aw_done && s_axi_awready) begin
				aw_done = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (!w_done && s_axi_wready) begin
				w_done = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
	endtask

	// One read; the address is held until taken, data is taken with rvalid.
	task automatic bus_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
		int n;
		logic ar_done;
		n = 0;
		ar_done = 1'b0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		forever begin
			@(posedge core_clk);
			n++;
			give_up(n);
			if (s_axi_rvalid && ar_done) begin
				d = s_axi_rdata;
				resp = s_axi_rresp;
				break;
			end
			if (!ar_done && s_axi_arready) begin
				ar_done = 1'b1;
				s_axi_arvalid <= 1'b0;
			end
		end
	endtask

	// Write that must be accepted with an OKAY response.
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [1:0] r;
		bus_write(a, d, r);
		check({30'h0, r}, {30'h0, `PMT_RESP_OKAY});
	endtask

	// Read that must return OKAY and the expected word.
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] d;
		logic [1:0] r;
		bus_read(a, d, r);
		check({30'h0, r}, {30'h0, `PMT_RESP_OKAY});
		check(d, exp);
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge core_clk);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence: each block of calls is one test.
	initial begin
		logic [31:0] d;
		logic [1:0] r;
		int div;
		logic saw_top;
		idle(16);
		resetn <= 1'b1;
		idle(1);
		// Reset values and the refused unmapped address.
		rd_chk(`PMT_OFF_CTRL, 32'h0);
		rd_chk(`PMT_OFF_PERIOD, 32'hff);
		rd_chk(`PMT_OFF_COUNT, 32'h0);
		rd_chk(`PMT_OFF_STATUS, 32'h0);
		rd_chk(`PMT_OFF_MASK, 32'h0);
		bus_read(8'h14, d, r);
		check({30'h0, r}, {30'h0, `PMT_RESP_SLVERR});
		check(d, 32'h0);
		bus_write(8'h14, 32'hff, r);
		check({30'h0, r}, {30'h0, `PMT_RESP_SLVERR});
		$display("Test reset values done");
		// Field layout, width and a stopped timer; bit 7 of control never sticks.
		wr(`PMT_OFF_CTRL, 32'hfb);
		rd_chk(`PMT_OFF_CTRL, 32'h7b);
		wr(`PMT_OFF_PERIOD, 32'h1a5);
		rd_chk(`PMT_OFF_PERIOD, 32'ha5);
		wr(`PMT_OFF_COUNT, 32'h33);
		wr(`PMT_OFF_CTRL, 32'h00);
		rd_chk(`PMT_OFF_COUNT, 32'h33);
		idle(100);
		rd_chk(`PMT_OFF_COUNT, 32'h33);
		$display("Test register access done");
		// Every prescale code: 80 * div clocks hold 20 increments of the quarter rate.
		for (int p = 0; p < 4; p++) begin
			div = (p == 0) ? 1 : (p == 1) ? 4 : 16;
			wr(`PMT_OFF_PERIOD, 32'hff);
			wr(`PMT_OFF_COUNT, 32'h0);
			wr(`PMT_OFF_CTRL, 32'h4 | p);
			idle(80 * div);
			wr(`PMT_OFF_CTRL, p);
			bus_read(`PMT_OFF_COUNT, d, r);
			check({31'h0, (d >= 32'd18 && d <= 32'd22)}, 32'h1);
		end
		$display("Test prescale done");
		// The count climbs to the period value and reloads, never passing it.
		wr(`PMT_OFF_PERIOD, 32'h5);
		wr(`PMT_OFF_COUNT, 32'h0);
		wr(`PMT_OFF_STATUS, 32'h1);
		wr(`PMT_OFF_CTRL, 32'h4);
		saw_top = 1'b0;
		for (int i = 0; i < 24; i++) begin
			bus_read(`PMT_OFF_COUNT, d, r);
			check({31'h0, (d <= 32'h5)}, 32'h1);
			saw_top = saw_top | (d === 32'h5);
		end
		check({31'h0, saw_top}, 32'h1);
		rd_chk(`PMT_OFF_STATUS, 32'h1);
		$display("Test period reload done");
		// Period 3 at divide by one gives a match every 16 clocks; flag after s+1 of them.
		foreach (ps_tab[i]) begin
			wr(`PMT_OFF_CTRL, 32'h0);
			wr(`PMT_OFF_COUNT, 32'h0);
			wr(`PMT_OFF_PERIOD, 32'h3);
			wr(`PMT_OFF_STATUS, 32'h1);
			wr(`PMT_OFF_CTRL, (ps_tab[i] << 3) | 32'h4);
			idle(ps_tab[i] * 16 + 8);
			rd_chk(`PMT_OFF_STATUS, 32'h0);
			idle(13);
			rd_chk(`PMT_OFF_STATUS, 32'h1);
		end
		$display("Test postscale done");
		// The request follows flag and enable together, and clears with the flag.
		wr(`PMT_OFF_CTRL, 32'h0);
		idle(2);
		check({31'h0, irq}, 32'h0);
		wr(`PMT_OFF_MASK, 32'h1);
		idle(2);
		check({31'h0, irq}, 32'h1);
		wr(`PMT_OFF_STATUS, 32'h1);
		idle(2);
		check({31'h0, irq}, 32'h0);
		rd_chk(`PMT_OFF_STATUS, 32'h0);
		$display("Test interrupt done");
		// Writes spaced under 16 instruction ticks must keep the divide-by-16 count as written.
		wr(`PMT_OFF_PERIOD, 32'hff);
		wr(`PMT_OFF_CTRL, 32'h6);
		idle(40);
		wr(`PMT_OFF_COUNT, 32'h40);
		idle(40);
		rd_chk(`PMT_OFF_COUNT, 32'h40);
		wr(`PMT_OFF_CTRL, 32'h6);
		idle(40);
		rd_chk(`PMT_OFF_COUNT, 32'h40);
		wr(`PMT_OFF_CTRL, 32'h0);
		$display("Test scaler clearing done");
		end_sim();
	end
endmodule
`default_nettype wire
